/* File: opl_pkg.sv */
// Package for the operator panel lamp block: lamp layout, register map, constants
package opl_pkg;

  // Number of storage cabinets feeding power-fail and thermostat lines
  localparam int STOR_CAB = 4;
  // First processor serial number that has the power-sequencing lamp
  localparam int POWER_SEQ_SERIAL = 205;

  // Lamp vector, bit 0 is the pending-launch lamp
  localparam int LAMP_W = 14;
  typedef struct packed {
    logic procHot;
    logic memHot;
    logic memPower;
    logic memMaint;
    logic procTest;
    logic powerSeq;
    logic cmpStop;
    logic ifaceFault;
    logic memParity;
    logic chanParity;
    logic periphIrq;
    logic loadFault;
    logic noData;
    logic launch;
  } opl_lamps_t;

  // Storage maintenance panel switches, high means not in normal position
  typedef struct packed {
    logic stackSwap;
    logic sideSwap;
    logic bitSwap;
    logic parityBypass;
    logic offline;
  } opl_maint_t;

  // Pins from outside the clock domain, synchronised as one vector
  typedef struct packed {
    opl_maint_t maint;
    logic [STOR_CAB-1:0] memPowerFail;
    logic [STOR_CAB-1:0] memThermo;
    logic procThermo;
    logic fullPower;
    logic panelClear;
  } opl_pins_t;
  localparam int PIN_W = $bits(opl_pins_t);

  // Register byte offsets
  localparam logic [3:0] REG_LAMPS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK = 4'hC;
  localparam int ADDR_W = 4;

  // Control register fields
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic CTRL_HALT_RESET = 1'b0;
  localparam logic [LAMP_W-1:0] MASK_RESET = 14'h0000;
  localparam logic [LAMP_W-1:0] LAMPS_OFF = 14'h0000;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: opl_panel.sv */
// Operator panel status lamps with AXI4-Lite status, control and interrupt registers
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module opl_panel
  import opl_pkg::*;
#(
  parameter int SERIAL_NUM = 205
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Initial load and channel events, processor clock domain
  input wire logic iplStart,
  input wire logic iplLaunch,
  input wire logic startStatus,
  input wire logic endStatus,
  input wire logic dataXfer,
  // Interrupt request and acceptance
  input wire logic irqPending,
  input wire logic irqAccept,
  // Error and stop events
  input wire logic chanParityErr,
  input wire logic memParityErr,
  input wire logic ifaceIllegal,
  input wire logic addrMatch,
  input wire logic offlineTest,
  input wire logic progReset,
  // Asynchronous pins: switches, power and thermostats
  input wire opl_pins_t pins,
  // Panel outputs
  output opl_lamps_t lamps,
  output logic alarm,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam logic POWER_SEQ_EN = (SERIAL_NUM >= POWER_SEQ_SERIAL);

  opl_pins_t pinMeta_q;
  opl_pins_t pinSync_q;
  opl_lamps_t lamp_q;
  opl_lamps_t lamp_d;
  opl_lamps_t lampPrev_q;
  logic pwrInit_q;
  logic alarm_q;
  logic haltOnMatch_q;
  logic softClear_q;
  logic [LAMP_W-1:0] irqStatus_q;
  logic [LAMP_W-1:0] irqMask_q;
  logic [LAMP_W-1:0] lampRise;
  logic [LAMP_W-1:0] w1cClear;
  logic latchClear;
  logic awHeld_q;
  logic wHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic [31:0] wMask;
  logic doWrite;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] readMux;
  logic readHit;
  logic writeHit;

  // Two-stage synchroniser; first stage only feeds the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end
    else
    begin
      pinMeta_q <= pins;
      pinSync_q <= pinMeta_q;
    end
  end

  // Clear for latched stop lamps
  assign latchClear = pinSync_q.panelClear | progReset | softClear_q;

  // Next lamp values; set beats clear in the same cycle, except on the interrupt lamp
  always_comb
  begin
    lamp_d = lamp_q;
    lamp_d.launch = iplLaunch | (lamp_q.launch & ~startStatus);
    lamp_d.noData = iplStart | (lamp_q.noData & ~dataXfer);
    lamp_d.loadFault = iplStart | (lamp_q.loadFault & ~endStatus);
    // Accept wins here: a serviced request must put the lamp out
    lamp_d.periphIrq = ~irqAccept & (irqPending | lamp_q.periphIrq);
    lamp_d.chanParity = chanParityErr | (lamp_q.chanParity & ~latchClear);
    lamp_d.memParity = memParityErr | (lamp_q.memParity & ~latchClear);
    lamp_d.ifaceFault = ifaceIllegal | (lamp_q.ifaceFault & ~latchClear);
    lamp_d.cmpStop = (addrMatch & haltOnMatch_q) | (lamp_q.cmpStop & ~latchClear);
    lamp_d.powerSeq = POWER_SEQ_EN & (~pwrInit_q | (lamp_q.powerSeq & ~pinSync_q.fullPower));
    lamp_d.procTest = offlineTest;
    lamp_d.memMaint = |pinSync_q.maint;
    lamp_d.memPower = (|pinSync_q.memPowerFail) | (lamp_q.memPower & ~latchClear);
    lamp_d.procHot = pinSync_q.procThermo;
    lamp_d.memHot = |pinSync_q.memThermo;
  end

  // Lamp flip-flops, all off under reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lamp_q <= LAMPS_OFF;
      lampPrev_q <= LAMPS_OFF;
    end
    else
    begin
      lamp_q <= lamp_d;
      lampPrev_q <= lamp_q;
    end
  end

  // Power-up marker; the lamp is lit on the first cycle out of reset
  always_ff @(posedge clk)
  begin
    if (rst)
      pwrInit_q <= 1'b0;
    else
      pwrInit_q <= 1'b1;
  end

  // Alarm registered from next lamp values so it tracks lamps exactly
  always_ff @(posedge clk)
  begin
    if (rst)
      alarm_q <= 1'b0;
    else
      alarm_q <= lamp_d.procHot | lamp_d.memHot;
  end

  assign lamps = lamp_q;
  assign alarm = alarm_q;

  // Lamp turn-on events feed the sticky interrupt status
  assign lampRise = lamp_q & ~lampPrev_q;
  assign wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  assign writeHit = (awAddr_q == REG_LAMPS) || (awAddr_q == REG_CTRL)
                 || (awAddr_q == REG_IRQ_STATUS) || (awAddr_q == REG_IRQ_MASK);
  assign doWrite = awHeld_q & wHeld_q & ~bvalid_q;
  assign w1cClear = (doWrite && awAddr_q == REG_IRQ_STATUS)
                  ? (wData_q[LAMP_W-1:0] & wMask[LAMP_W-1:0]) : LAMPS_OFF;

  // Sticky status, one bit per lamp; a new event beats a clear
  genvar gi;
  generate
    for (gi = 0; gi < LAMP_W; gi++)
    begin : g_status
      always_ff @(posedge clk)
      begin
        if (rst)
          irqStatus_q[gi] <= 1'b0;
        else
          irqStatus_q[gi] <= lampRise[gi] | (irqStatus_q[gi] & ~w1cClear[gi]);
      end
    end
  endgenerate

  // Level interrupt from unmasked sticky bits
  assign irq = |(irqStatus_q & irqMask_q);

  // Software control and mask registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      haltOnMatch_q <= CTRL_HALT_RESET;
      softClear_q <= 1'b0;
      irqMask_q <= MASK_RESET;
    end
    else
    begin
      softClear_q <= 1'b0;
      if (doWrite && awAddr_q == REG_CTRL && wStrb_q[0])
      begin
        haltOnMatch_q <= wData_q[CTRL_HALT_BIT];
        softClear_q <= wData_q[CTRL_CLEAR_BIT];
      end
      if (doWrite && awAddr_q == REG_IRQ_MASK)
        irqMask_q <= (irqMask_q & ~wMask[LAMP_W-1:0]) | (wData_q[LAMP_W-1:0] & wMask[LAMP_W-1:0]);
    end
  end

  // Write address and data are taken independently and held until both arrive
  assign s_axi_awready = ~awHeld_q & ~bvalid_q;
  assign s_axi_wready = ~wHeld_q & ~bvalid_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end
    else if (doWrite)
      awHeld_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld_q <= 1'b1;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end
    else if (doWrite)
      wHeld_q <= 1'b0;
  end

  // Write response; the lamp register is read-only and ignores writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= writeHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read decode
  always_comb
  begin
    readMux = '0;
    readHit = 1'b1;
    unique case (s_axi_araddr)
      REG_LAMPS: readMux[LAMP_W-1:0] = lamp_q;
      REG_CTRL: readMux[CTRL_HALT_BIT] = haltOnMatch_q;
      REG_IRQ_STATUS: readMux[LAMP_W-1:0] = irqStatus_q;
      REG_IRQ_MASK: readMux[LAMP_W-1:0] = irqMask_q;
      default: readHit = 1'b0;
    endcase
  end

  // One read at a time; address refused while data waits
  assign s_axi_arready = ~rvalid_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= readMux;
      rresp_q <= readHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Checks on lamp behaviour
  a_launch_set: assert property (@(posedge clk) disable iff (rst)
    iplLaunch |=> lamps.launch) else $error("launch lamp not lit");
  a_launch_clear: assert property (@(posedge clk) disable iff (rst)
    startStatus && !iplLaunch |=> !lamps.launch) else $error("launch lamp not cleared");
  a_nodata_clear: assert property (@(posedge clk) disable iff (rst)
    dataXfer && !iplStart |=> !lamps.noData) else $error("no-transfer lamp stuck");
  a_fault_hold: assert property (@(posedge clk) disable iff (rst)
    lamps.loadFault && !endStatus |=> lamps.loadFault) else $error("load fault lost");
  a_irq_lamp: assert property (@(posedge clk) disable iff (rst)
    irqPending && !irqAccept |=> lamps.periphIrq) else $error("interrupt lamp not lit");
  a_irq_hold: assert property (@(posedge clk) disable iff (rst)
    lamps.periphIrq && !irqAccept |=> lamps.periphIrq) else $error("interrupt lamp dropped");
  a_irq_accept: assert property (@(posedge clk) disable iff (rst)
    irqAccept |=> !lamps.periphIrq) else $error("interrupt lamp kept after accept");
  a_parity_latch: assert property (@(posedge clk) disable iff (rst)
    chanParityErr ##1 (!latchClear)[*2] |=> lamps.chanParity)
    else $error("channel parity lamp lost");
  a_mem_parity: assert property (@(posedge clk) disable iff (rst)
    memParityErr |=> lamps.memParity) else $error("memory parity lamp not lit");
  a_iface_fault: assert property (@(posedge clk) disable iff (rst)
    ifaceIllegal |=> lamps.ifaceFault) else $error("interface fault lamp not lit");
  a_cmp_gate: assert property (@(posedge clk) disable iff (rst)
    !lamps.cmpStop && !(addrMatch && haltOnMatch_q) |=> !lamps.cmpStop)
    else $error("compare stop without halt enable");
  a_power_seq: assert property (@(posedge clk) disable iff (rst)
    POWER_SEQ_EN && $fell(rst) |=> lamps.powerSeq) else $error("power lamp not lit");
  a_test_mode: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> lamps.procTest == $past(offlineTest)) else $error("test lamp wrong");
  a_proc_temp: assert property (@(posedge clk) disable iff (rst)
    pins.procThermo[*3] |=> lamps.procHot && alarm) else $error("overheat late");
  a_clear_latch: assert property (@(posedge clk) disable iff (rst)
    latchClear && !memParityErr |=> !lamps.memParity) else $error("latched lamp not cleared");
  a_alarm_lamps: assert property (@(posedge clk) disable iff (rst)
    alarm == (lamps.procHot || lamps.memHot)) else $error("alarm mismatch");

endmodule

/* File: opl_operator.sv */
// Behavioural operator who presses the panel clear switch when the bench asks
`timescale 1ns/1ps
module opl_operator (
  // Clock
  input wire logic clk,
  // Bench request to press clear
  input wire logic press,
  // Switch contact
  output logic panelClear
);
  logic [3:0] holdQ = 4'h0;

  // A human press spans many cycles, so the pin synchroniser cannot miss it
  always_ff @(posedge clk)
  begin
    if (press)
      holdQ <= 4'h8;
    else if (holdQ != 4'h0)
      holdQ <= holdQ - 4'h1;
  end
  assign panelClear = (holdQ != 4'h0);
endmodule

/* File: opl_panel_test.sv */
// Self-checking bench for the operator panel lamp block
`timescale 1ns/1ps
module opl_panel_test
  import opl_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [12:0] ev = '0;
  opl_pins_t pinsTb = '0;
  opl_pins_t pinsBus;
  logic press = 1'b0;
  logic panelClear, alarm, irq;
  opl_lamps_t lamps;
  logic [3:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [49:0] q[$];
  logic [49:0] obs;
  int fails = 0, checkCount = 0, seed = 32'h940d, r;
  opl_lamps_t expL = '0;
  logic expIrq = 1'b0;

  // 50 MHz clock
  always #10 clk = ~clk;

  // Clear switch comes from the operator model
  assign pinsBus = {pinsTb[PIN_W-1:1], panelClear};
  opl_operator u_operator (.clk(clk), .press(press), .panelClear(panelClear));
  opl_panel #(.SERIAL_NUM(POWER_SEQ_SERIAL)) u_dut (
    .clk(clk), .rst(rst), .iplStart(ev[0]), .iplLaunch(ev[1]), .startStatus(ev[2]),
    .endStatus(ev[3]), .dataXfer(ev[4]), .irqPending(ev[5]), .irqAccept(ev[6]),
    .chanParityErr(ev[7]), .memParityErr(ev[8]), .ifaceIllegal(ev[9]), .addrMatch(ev[10]),
    .offlineTest(ev[11]), .progReset(ev[12]), .pins(pinsBus), .lamps(lamps), .alarm(alarm),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic chk(string nm, logic [49:0] seen, logic [49:0] want);
    checkCount++;
    if (seen !== want)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, want, seen);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && checkCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Write: address and data offered together, each released once taken
  task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] rsp);
    logic done;
    done = 1'b0;
    @(posedge clk);
    q.push_back({16'h0000, rsp, 32'h0000_0000});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Read: the note also holds the lamp, alarm and interrupt pins expected
  task automatic rd(logic [3:0] a, logic [1:0] rsp, logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk);
    q.push_back({expIrq, expL.procHot | expL.memHot, expL, rsp, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic look();
    rd(REG_LAMPS, RESP_OKAY, {18'h0_0000, expL});
  endtask

  task automatic pulse(int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
  endtask

  // Pins need two synchroniser stages before the lamp moves
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  // Compare each bus answer with the oldest note
  always @(posedge clk)
  begin
    if (!rst && (bvalid && bready || rvalid && rready))
    begin
      obs = bvalid ? {16'h0000, bresp, 32'h0000_0000} : {irq, alarm, lamps, rresp, rdata};
      chk("bus answer", obs, (q.size() != 0) ? q.pop_front() : 'x);
    end
  end

  // Main sequence
  initial
  begin
    static int evb[10] = '{0, 1, 2, 4, 3, 7, 8, 9, 10, 12};
    static logic [13:0] lv[10] = '{14'h0006, 14'h0007, 14'h0006, 14'h0004, 14'h0000,
      14'h0010, 14'h0030, 14'h0070, 14'h0070, 14'h0000};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    expL.powerSeq = 1'b1;
    look();
    rd(REG_CTRL, RESP_OKAY, 32'h0000_0000);
    wr(REG_IRQ_STATUS, 32'h0000_3FFF, RESP_OKAY);
    rd(REG_IRQ_STATUS, RESP_OKAY, 32'h0000_0000);
    r = $random(seed);
    wr(REG_IRQ_MASK, r, RESP_OKAY);
    rd(REG_IRQ_MASK, RESP_OKAY, r & 32'h0000_3FFF);
    wr(REG_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    wr(REG_LAMPS, 32'hFFFF_FFFF, RESP_OKAY);
    wr(4'h2, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(4'h2, RESP_SLVERR, 32'h0000_0000);
    pinsTb.fullPower <= 1'b1;
    settle();
    expL.powerSeq = 1'b0;
    look();
    pinsTb.fullPower <= 1'b0;
    settle();
    look();
    for (int i = 0; i < 10; i++)
    begin
      pulse(evb[i]);
      expL = lv[i];
      look();
    end
    wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    pulse(10);
    expL.cmpStop = 1'b1;
    look();
    wr(REG_CTRL, 32'h0000_0003, RESP_OKAY);
    expL.cmpStop = 1'b0;
    look();
    rd(REG_CTRL, RESP_OKAY, 32'h0000_0001);
    pulse(7);
    press <= 1'b1;
    @(posedge clk);
    press <= 1'b0;
    repeat (14) @(posedge clk);
    look();
    wr(REG_IRQ_STATUS, 32'h0000_3FFF, RESP_OKAY);
    wr(REG_IRQ_MASK, 32'h0000_0008, RESP_OKAY);
    ev[5] <= 1'b1;
    settle();
    expL.periphIrq = 1'b1;
    expIrq = 1'b1;
    look();
    ev[5] <= 1'b0;
    settle();
    look();
    pulse(6);
    expL.periphIrq = 1'b0;
    look();
    wr(REG_IRQ_STATUS, 32'h0000_0008, RESP_OKAY);
    expIrq = 1'b0;
    wr(REG_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    pulse(5);
    expL.periphIrq = 1'b1;
    look();
    wr(REG_IRQ_MASK, 32'h0000_0008, RESP_OKAY);
    expIrq = 1'b1;
    look();
    pulse(6);
    wr(REG_IRQ_STATUS, 32'h0000_3FFF, RESP_OKAY);
    wr(REG_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    expIrq = 1'b0;
    expL.periphIrq = 1'b0;
    ev[11] <= 1'b1;
    settle();
    expL.procTest = 1'b1;
    look();
    ev[11] <= 1'b0;
    settle();
    expL.procTest = 1'b0;
    // Every maintenance switch alone must light the lamp
    for (int i = 0; i < 5; i++)
    begin
      pinsTb.maint <= 5'(1 << i);
      settle();
      expL.memMaint = 1'b1;
      look();
      pinsTb.maint <= '0;
      settle();
      expL.memMaint = 1'b0;
    end
    look();
    r = $random(seed);
    pinsTb.memPowerFail <= 4'(1 << r[1:0]);
    settle();
    pinsTb.memPowerFail <= 4'h0;
    expL.memPower = 1'b1;
    settle();
    look();
    pulse(12);
    expL.memPower = 1'b0;
    look();
    pinsTb.procThermo <= 1'b1;
    settle();
    expL.procHot = 1'b1;
    look();
    r = $random(seed);
    pinsTb.memThermo <= r[3:0] | 4'h1;
    pinsTb.procThermo <= 1'b0;
    settle();
    expL.procHot = 1'b0;
    expL.memHot = 1'b1;
    look();
    pinsTb.memThermo <= 4'h0;
    settle();
    expL.memHot = 1'b0;
    look();
    pulse(8);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    expL = '0;
    expL.powerSeq = 1'b1;
    look();
    // The monitor takes the last answer at this same edge; let it run first
    @(posedge clk);
    chk("pending notes", q.size(), '0);
    end_of_test();
  end

  // Cut a hang short far beyond the few hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule
